// >>> can_store_cfg.svh
`ifndef CAN_STORE_CFG_SVH
`define CAN_STORE_CFG_SVH

// ****************************************
// Byte positions inside one buffer window
// ****************************************
`define POS_IDENT0      4'h0
`define POS_IDENT1      4'h1
`define POS_IDENT2      4'h2
`define POS_IDENT3      4'h3
`define POS_DATA0       4'h4
`define POS_LENGTH      4'hC
`define POS_RANK        4'hD
`define POS_STAMP_HI    4'hE
`define POS_STAMP_LO    4'hF

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define WIN_TX          2'b00
`define WIN_RX          2'b01
`define IDX_SELECT      6'h20
`define IDX_EMPTY       6'h21
`define IDX_CONTROL     6'h22
`define IDX_INT_STATUS  6'h23
`define IDX_INT_MASK    6'h24

// ****************************************
// Fields, reset values and counts
// ****************************************
`define BIT_INIT        0
`define BIT_TIME        1
`define IDE_POS         3
`define RTR_STD_POS     4
`define SRR_EXT         1'b1
`define RX_SLOT         2'h3
`define RX_INT_BIT      3
`define EMPTY_RESET     3'h7
`define MAX_BYTES       4'h8
`define BIT_DIV_DEFAULT 20

`endif

// >>> can_store_pkg.sv
package can_store_pkg;

    // Bus phase tracking
    typedef enum logic [1:0]
    {
        BUS_IDLE      = 2'b00,
        BUS_WRITE     = 2'b01,
        BUS_READ_WAIT = 2'b10,
        BUS_READ_DONE = 2'b11
    } bus_state_e;

    // One buffer of sixteen byte registers
    typedef logic [15:0][7:0] buffer_t;

    // Whole state of the store
    typedef struct packed {
        buffer_t [3:0] mem;
        logic [2:0]    emptyFlags;
        logic [2:0]    selectReg;
        logic          initMode;
        logic          timeEnable;
        logic [3:0]    intStatus;
        logic [3:0]    intMask;
        logic [15:0]   stampValue;
        logic [7:0]    divCount;
        bus_state_e    busState;
        logic [5:0]    busIndex;
        logic          busMapped;
        logic [31:0]   readData;
        logic          activeValid;
        logic [1:0]    activeIndex;
        logic [28:0]   txId;
        logic          txIde;
        logic          txRtr;
        logic [3:0]    txDlc;
        logic [3:0]    txByteCount;
        logic [63:0]   txData;
    } state_s;

endpackage

// >>> can_tx_arbiter.sv
`timescale 1ns/10ps

module can_tx_arbiter
#(
    parameter int N = 3
)
(
    input  wire logic [N-1:0]      pending,
    input  wire logic [N-1:0][7:0] ranks,
    output logic                   winValid,
    output logic [1:0]             winIndex
);

    if (N < 1 || N > 4)
    begin : gen_check
        $error("can_tx_arbiter: N must be 1 to 4");
    end

    // Lowest rank wins, lower index kept on a tie
    always_comb
    begin
        logic [7:0] best;
        best     = 8'hFF;
        winValid = 1'b0;
        winIndex = 2'h0;
        for (int i = 0; i < N; i++)
        begin
            if (pending[i] && (!winValid || ranks[i] < best))
            begin
                winValid = 1'b1;
                winIndex = 2'(i);
                best     = ranks[i];
            end
        end
    end

endmodule

// >>> can_msg_store.sv
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "can_store_cfg.svh"

// Overview of operation
// - Standard identifier eleven bits, MSB first
// - Low identifier bits in ident byte one
// - Remote bit four: data or remote
// - Extension bit three picks identifier format
// - Eight data bytes, count from length
// - Length code bits three to zero
// - Remote frame sends code, zero bytes
// - Eight-bit local rank per transmit buffer
// - Pending buffers compete just before start
// - Lowest rank wins, lower index ties
// - Stamp written after valid frame end
// - Sixteen-bit free-running bit-clock timer, wraps to zero on overflow
// - Timer held zero in initialization mode
// - Stamp read-only, gated by empty, selected
// - Software clears empty, controller sets again
// - Extended identifier twenty-nine bits, MSB first

module can_msg_store
#(
    parameter int BIT_DIV = `BIT_DIV_DEFAULT
)
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sofRequest,
    input  wire logic        txDone,
    input  wire logic        txFail,
    output logic             txActive,
    output logic [1:0]       txIndex,
    output logic [28:0]      txId,
    output logic             txIde,
    output logic             txRtr,
    output logic [3:0]       txDlc,
    output logic [3:0]       txByteCount,
    output logic [63:0]      txData,
    input  wire logic        rxValid,
    input  wire logic [28:0] rxId,
    input  wire logic        rxIde,
    input  wire logic        rxRtr,
    input  wire logic [3:0]  rxDlc,
    input  wire logic [63:0] rxData,
    output logic             bitTick,
    output logic             initMode,
    output logic             irq
);

    if (BIT_DIV < 2 || BIT_DIV > 256)
    begin : gen_check
        $error("can_msg_store: BIT_DIV must be 2 to 256");
    end

    // ****************************************
    // Helper functions
    // ****************************************

    // Bytes carried by a frame
    function automatic logic [3:0] byte_count(input logic [3:0] dlc, input logic rtr);
        if (rtr)
            return 4'h0;
        else if (dlc > `MAX_BYTES)
            return `MAX_BYTES;
        else
            return dlc;
    endfunction

    // Identifier bytes zero to three of a buffer
    function automatic logic [31:0] pack_ident(input logic [28:0] id, input logic ide,
                                               input logic rtr);
        if (ide)
            return {id[28:21], id[20:18], `SRR_EXT, 1'b1, id[17:15],
                    id[14:7], id[6:0], rtr};
        else
            return {id[10:3], id[2:0], rtr, 1'b0, 3'h0, 16'h0000};
    endfunction

    // ****************************************
    // Signals
    // ****************************************
    can_store_pkg::state_s s;
    can_store_pkg::state_s next_s;
    logic                  selValid;
    logic [1:0]            selIndex;
    logic [2:0]            pending;
    logic [2:0][7:0]       ranks;
    logic                  winValid;
    logic [1:0]            winIndex;
    logic                  addrPhase;
    logic [31:0]           rxIdent;
    logic [3:0]            rxCount;

    // ****************************************
    // Selection and arbitration
    // ****************************************

    // Lowest set select bit maps into the window
    always_comb
    begin
        selValid = 1'b0;
        selIndex = 2'h0;
        for (int i = 2; i >= 0; i--)
        begin
            if (s.selectReg[i])
            begin
                selValid = 1'b1;
                selIndex = 2'(i);
            end
        end
    end

    // Full buffers compete when a frame starts
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            pending[i] = !s.emptyFlags[i] && !s.initMode;
            ranks[i]   = s.mem[i][`POS_RANK];
        end
    end

    can_tx_arbiter
    #(
        .N        (3)
    )
    u_can_tx_arbiter
    (
        .pending  (pending),
        .ranks    (ranks),
        .winValid (winValid),
        .winIndex (winIndex)
    );

    assign addrPhase = hsel && htrans[1] && hready;
    assign rxIdent   = pack_ident(rxId, rxIde, rxRtr);
    assign rxCount   = byte_count(rxDlc, rxRtr);

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic [5:0]  idx;
        logic [1:0]  w;
        logic [3:0]  cnt;
        logic [7:0]  wByte;
        can_store_pkg::buffer_t b;
        next_s = s;
        idx    = s.busIndex;
        wByte  = hwdata[7:0];
        w      = winIndex;
        b      = s.mem[winIndex];
        cnt    = 4'h0;

        // Bit clock divider and stamp timer
        if (s.divCount == 8'(BIT_DIV - 1))
            next_s.divCount = 8'h00;
        else
            next_s.divCount = s.divCount + 8'h01;
        if (s.initMode)
            next_s.stampValue = 16'h0000;
        else if (s.divCount == 8'(BIT_DIV - 1))
            next_s.stampValue = s.stampValue + 16'h0001;

        // Bus data phase
        case (s.busState)
            can_store_pkg::BUS_WRITE:
            begin
                if (s.busMapped && idx[5:4] == `WIN_TX)
                begin
                    // Only an empty selected buffer takes writes; stamp is read-only
                    if (selValid && s.emptyFlags[selIndex] &&
                        idx[3:0] <= `POS_RANK)
                        next_s.mem[selIndex][idx[3:0]] = wByte;
                end
                else if (s.busMapped)
                begin
                    case (idx)
                        `IDX_SELECT:     next_s.selectReg = wByte[2:0];
                        `IDX_EMPTY:      next_s.emptyFlags = s.emptyFlags & ~wByte[2:0];
                        `IDX_CONTROL:
                        begin
                            next_s.initMode   = wByte[`BIT_INIT];
                            next_s.timeEnable = wByte[`BIT_TIME];
                        end
                        `IDX_INT_MASK:   next_s.intMask = wByte[3:0];
                        default:         next_s.intMask = s.intMask;
                    endcase
                end
            end
            can_store_pkg::BUS_READ_WAIT:
            begin
                next_s.readData = 32'h0000_0000;
                if (!s.busMapped)
                    next_s.readData = 32'h0000_0000;
                else if (idx[5:4] == `WIN_TX)
                begin
                    if (selValid && (idx[3:0] < `POS_RANK || s.emptyFlags[selIndex]))
                        next_s.readData[7:0] = s.mem[selIndex][idx[3:0]];
                end
                else if (idx[5:4] == `WIN_RX)
                    next_s.readData[7:0] = s.mem[`RX_SLOT][idx[3:0]];
                else
                begin
                    case (idx)
                        `IDX_SELECT:     next_s.readData[2:0] = s.selectReg;
                        `IDX_EMPTY:      next_s.readData[2:0] = s.emptyFlags;
                        `IDX_CONTROL:    next_s.readData[1:0] = {s.timeEnable, s.initMode};
                        `IDX_INT_STATUS:
                        begin
                            next_s.readData[3:0] = s.intStatus;
                            next_s.intStatus     = 4'h0;
                        end
                        `IDX_INT_MASK:   next_s.readData[3:0] = s.intMask;
                        default:         next_s.readData = 32'h0000_0000;
                    endcase
                end
            end
            default:
            begin
                next_s.readData = s.readData;
            end
        endcase

        // Bus address phase
        if (addrPhase)
        begin
            next_s.busIndex  = haddr[7:2];
            next_s.busMapped = (haddr[31:8] == 24'h000000);
            next_s.busState  = hwrite ? can_store_pkg::BUS_WRITE
                                      : can_store_pkg::BUS_READ_WAIT;
        end
        else if (s.busState == can_store_pkg::BUS_READ_WAIT)
            next_s.busState = can_store_pkg::BUS_READ_DONE;
        else
            next_s.busState = can_store_pkg::BUS_IDLE;

        // Load the winning buffer for the engine
        if (sofRequest && winValid && !s.activeValid)
        begin
            next_s.activeValid = 1'b1;
            next_s.activeIndex = w;
            next_s.txIde       = b[`POS_IDENT1][`IDE_POS];
            if (b[`POS_IDENT1][`IDE_POS])
            begin
                next_s.txId  = {b[0], b[1][7:5], b[1][2:0], b[2], b[3][7:1]};
                next_s.txRtr = b[`POS_IDENT3][0];
            end
            else
            begin
                next_s.txId  = {18'h00000, b[0], b[1][7:5]};
                next_s.txRtr = b[`POS_IDENT1][`RTR_STD_POS];
            end
            next_s.txDlc = b[`POS_LENGTH][3:0];
            cnt          = byte_count(b[`POS_LENGTH][3:0], next_s.txRtr);
            next_s.txByteCount = cnt;
            for (int i = 0; i < 8; i++)
                next_s.txData[i*8 +: 8] = (4'(i) < cnt) ? b[`POS_DATA0 + 4'(i)]
                                                        : 8'h00;
        end

        // Transmit outcome
        if (s.activeValid && txDone)
        begin
            next_s.activeValid                 = 1'b0;
            next_s.emptyFlags[s.activeIndex]   = 1'b1;
            next_s.intStatus[s.activeIndex]    = 1'b1;
            if (s.timeEnable)
            begin
                next_s.mem[s.activeIndex][`POS_STAMP_HI] = s.stampValue[15:8];
                next_s.mem[s.activeIndex][`POS_STAMP_LO] = s.stampValue[7:0];
            end
        end
        else if (s.activeValid && txFail)
            next_s.activeValid = 1'b0;

        // Receive capture into the foreground buffer
        if (rxValid)
        begin
            next_s.mem[`RX_SLOT][`POS_IDENT0] = rxIdent[31:24];
            next_s.mem[`RX_SLOT][`POS_IDENT1] = rxIdent[23:16];
            next_s.mem[`RX_SLOT][`POS_IDENT2] = rxIdent[15:8];
            next_s.mem[`RX_SLOT][`POS_IDENT3] = rxIdent[7:0];
            next_s.mem[`RX_SLOT][`POS_LENGTH] = {4'h0, rxDlc};
            for (int i = 0; i < 8; i++)
                if (4'(i) < rxCount)
                    next_s.mem[`RX_SLOT][`POS_DATA0 + 4'(i)] = rxData[i*8 +: 8];
            if (s.timeEnable)
            begin
                next_s.mem[`RX_SLOT][`POS_STAMP_HI] = s.stampValue[15:8];
                next_s.mem[`RX_SLOT][`POS_STAMP_LO] = s.stampValue[7:0];
            end
            next_s.intStatus[`RX_INT_BIT] = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s            <= '0;
            s.emptyFlags <= `EMPTY_RESET;
            s.initMode   <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hreadyout   = (s.busState != can_store_pkg::BUS_READ_WAIT);
    assign hresp       = 1'b0;
    assign hrdata      = s.readData;
    assign txActive    = s.activeValid;
    assign txIndex     = s.activeIndex;
    assign txId        = s.txId;
    assign txIde       = s.txIde;
    assign txRtr       = s.txRtr;
    assign txDlc       = s.txDlc;
    assign txByteCount = s.txByteCount;
    assign txData      = s.txData;
    assign bitTick     = (s.divCount == 8'(BIT_DIV - 1));
    assign initMode    = s.initMode;
    assign irq         = |(s.intStatus & s.intMask);

endmodule

// >>> can_msg_store_sva.sv
`timescale 1ns/10ps

module can_msg_store_sva
#(
    parameter int BIT_DIV = 20
)
(
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        sofRequest,
    input wire logic        txDone,
    input wire logic        txFail,
    input wire logic        txActive,
    input wire logic [1:0]  txIndex,
    input wire logic [28:0] txId,
    input wire logic        txIde,
    input wire logic        txRtr,
    input wire logic [3:0]  txDlc,
    input wire logic [3:0]  txByteCount,
    input wire logic [63:0] txData,
    input wire logic        bitTick,
    input wire logic        initMode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // ****************************************
    // Tick spacing helper
    // ****************************************
    int   gap;
    logic seen;

    // Cycles since the last tick
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gap  <= 0;
            seen <= 1'b0;
        end
        else
        begin
            gap  <= bitTick ? 0 : gap + 1;
            seen <= seen | bitTick;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    property p_start; $rose(txActive) |-> $past(sofRequest) && !$past(initMode); endproperty
    a_start: assert property (p_start) else $error("tx began without start");
    property p_idle; sofRequest && !txActive && initMode |=> !txActive; endproperty
    a_idle: assert property (p_idle) else $error("tx began in init mode");
    property p_hold; txActive && !txDone && !txFail |=> txActive && $stable(txIndex); endproperty
    a_hold: assert property (p_hold) else $error("tx dropped early");
    property p_end; txActive && (txDone || txFail) |=> !txActive; endproperty
    a_end: assert property (p_end) else $error("tx not released");
    property p_remote; txActive && txRtr |-> txByteCount == 4'h0; endproperty
    a_remote: assert property (p_remote) else $error("remote frame has bytes");
    property p_count;
        txActive && !txRtr |-> txByteCount == ((txDlc > 4'h8) ? 4'h8 : txDlc);
    endproperty
    a_count: assert property (p_count) else $error("byte count off");
    property p_unused; txActive |-> (txData >> {txByteCount, 3'b000}) == 64'h0; endproperty
    a_unused: assert property (p_unused) else $error("bytes beyond count");
    property p_stdid; txActive && !txIde |-> txId[28:11] == 18'h0; endproperty
    a_stdid: assert property (p_stdid) else $error("standard id too wide");
    property p_tick; bitTick && seen |-> gap == BIT_DIV - 1; endproperty
    a_tick: assert property (p_tick) else $error("tick spacing off");

    // Main scenarios reached
    c_remote: cover property (txActive && txRtr);
    c_fail: cover property (txActive && txFail);
    c_done: cover property (txActive && txDone);
endmodule

// >>> can_node_model.sv
`timescale 1ns/10ps

module can_node_model
(
    input  wire logic        clock,
    input  wire logic        txActive,
    output logic             sofRequest,
    output logic             txDone,
    output logic             txFail,
    output logic             rxValid,
    output logic [28:0]      rxId,
    output logic             rxIde,
    output logic             rxRtr,
    output logic [3:0]       rxDlc,
    output logic [63:0]      rxData
);
    // Quiet bus at time zero
    initial
    begin
        {sofRequest, txDone, txFail, rxValid} = 4'h0;
        {rxId, rxIde, rxRtr, rxDlc, rxData} = '0;
    end

    // Arbitration opens: start of frame pulse
    task automatic startFrame();
        @(posedge clock);
        sofRequest <= 1'b1;
        @(posedge clock);
        sofRequest <= 1'b0;
    endtask

    // Frame ends after gap cycles, sent or lost
    task automatic endFrame(input int gap, input logic bad);
        repeat (gap) @(posedge clock);
        txDone <= txActive & ~bad;
        txFail <= txActive & bad;
        @(posedge clock);
        txDone <= 1'b0;
        txFail <= 1'b0;
    endtask

    // Valid frame after end of frame, fields scrambled after
    task automatic sendRx(input logic [28:0] id, input logic ide, input logic [3:0] dlc,
                          input logic [63:0] d);
        @(posedge clock);
        rxValid <= 1'b1;
        {rxId, rxIde, rxRtr, rxDlc, rxData} <= {id, ide, 1'b0, dlc, d};
        @(posedge clock);
        rxValid <= 1'b0;
        {rxId, rxIde, rxRtr, rxDlc, rxData} <= ~{id, ide, 1'b0, dlc, d};
    endtask
endmodule

// >>> can_msg_store_bench.sv
`timescale 1ns/10ps

module can_msg_store_bench;
    localparam int DIV = 4;
    logic        clock, arst_n, hsel, hwrite, hreadyout, hresp, bitTick, initMode, irq;
    logic        sofRequest, txDone, txFail, txActive, txIde, txRtr, rxValid, rxIde, rxRtr;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, txIndex;
    logic [28:0] txId, rxId;
    logic [3:0]  txDlc, txByteCount, rxDlc;
    logic [63:0] txData, rxData;
    logic [15:0] ticks, tickDone, stamp;
    logic [7:0]  rank [3] = '{8'h05, 8'h03, 8'h03};
    logic [3:0]  dlc [3] = '{4'h8, 4'h3, 4'h5};
    logic [28:0] xid = 29'h0ABCDE12;
    int          failures, num_checks, cycles;

    can_msg_store #(.BIT_DIV(DIV)) u_can_msg_store (.clock, .arst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .sofRequest, .txDone, .txFail, .txActive, .txIndex, .txId, .txIde, .txRtr, .txDlc,
        .txByteCount, .txData, .rxValid, .rxId, .rxIde, .rxRtr, .rxDlc, .rxData, .bitTick,
        .initMode, .irq);
    can_node_model u_can_node_model (.clock, .txActive, .sofRequest, .txDone, .txFail,
        .rxValid, .rxId, .rxIde, .rxRtr, .rxDlc, .rxData);

    // Clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Timeout and bit tick count
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        ticks <= initMode ? 16'h0 : ticks + 16'(bitTick);
        if (txDone && txActive)
            tickDone <= ticks;
        if (cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One AHB single word transfer
    task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 24'h0, idx, 2'b00};
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(i, 1'b1, d);
    endtask

    task automatic rdc(input logic [5:0] i, input logic [7:0] e);
        bus(i, 1'b0, 8'h00);
        chk(rd, {24'h0, e});
        chk(hresp, 1'b0);
    endtask

    // Start a frame and compare what the engine is handed
    task automatic txChk(input logic [1:0] b, input logic [3:0] cnt);
        u_can_node_model.startFrame();
        @(posedge clock);
        chk(txActive, 1'b1);
        chk(txIndex, b);
        chk(txId, {18'h0, 11'h2A0 | b});
        chk({txRtr, txIde, txDlc}, {b == 2'd2, 1'b0, dlc[b]});
        chk(txByteCount, cnt);
        chk(txData, (64'h8877665544332211 ^ {8{6'h0, b}}) & 64'((65'h1 << {cnt, 3'b0}) - 1));
    endtask

    task automatic wrap_up();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {arst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {failures, num_checks, cycles} = '0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rdc(6'h0D, 8'h00);
        for (int b = 0; b < 3; b++)
        begin
            wr(6'h20, 8'h01 << b);
            rdc(6'h0D, 8'h00);
            wr(6'h00, 8'h54);
            wr(6'h01, {b[2:0], b == 2, 4'h0});
            for (int i = 0; i < 8; i++)
                wr(6'(4 + i), 8'(8'h11 * (i + 1)) ^ 8'(b));
            wr(6'h0C, {4'h0, dlc[b]});
            wr(6'h0D, rank[b]);
        end
        rdc(6'h0D, 8'h03);
        wr(6'h0E, 8'hAA);
        rdc(6'h0E, 8'h00);
        wr(6'h24, 8'h07);
        wr(6'h22, 8'h02);
        wr(6'h21, 8'h07);
        rdc(6'h21, 8'h00);
        rdc(6'h0D, 8'h00);
        wr(6'h0D, 8'h00);
        txChk(2'd1, 4'h3);
        u_can_node_model.endFrame(3, 1'b1);
        txChk(2'd1, 4'h3);
        u_can_node_model.endFrame(5, 1'b0);
        @(posedge clock);
        chk(irq, 1'b1);
        rdc(6'h21, 8'h02);
        rdc(6'h23, 8'h02);
        chk(irq, 1'b0);
        wr(6'h20, 8'h02);
        bus(6'h0E, 1'b0, 8'h00);
        stamp[15:8] = rd[7:0];
        bus(6'h0F, 1'b0, 8'h00);
        stamp[7:0] = rd[7:0];
        chk(stamp + 16'h1 >= tickDone && stamp <= tickDone + 16'h1 && stamp != 0, 1'b1);
        txChk(2'd2, 4'h0);
        u_can_node_model.endFrame(2, 1'b0);
        txChk(2'd0, 4'h8);
        u_can_node_model.endFrame(2, 1'b0);
        wr(6'h20, 8'h01);
        wr(6'h00, xid[28:21]);
        wr(6'h01, {xid[20:18], 2'b11, xid[17:15]});
        wr(6'h02, xid[14:7]);
        wr(6'h03, {xid[6:0], 1'b1});
        wr(6'h21, 8'h01);
        u_can_node_model.startFrame();
        @(posedge clock);
        chk({txIde, txRtr, txId}, {2'b11, xid});
        chk({txDlc, txByteCount}, {4'h8, 4'h0});
        u_can_node_model.endFrame(2, 1'b0);
        u_can_node_model.startFrame();
        @(posedge clock);
        chk(txActive, 1'b0);
        wr(6'h22, 8'h03);
        wr(6'h21, 8'h01);
        u_can_node_model.startFrame();
        @(posedge clock);
        chk(txActive, 1'b0);
        u_can_node_model.sendRx(xid, 1'b1, 4'h2, 64'h00000000_0000BBAA);
        rdc(6'h10, xid[28:21]);
        rdc(6'h11, {xid[20:18], 2'b11, xid[17:15]});
        rdc(6'h12, xid[14:7]);
        rdc(6'h13, {xid[6:0], 1'b0});
        rdc(6'h1C, 8'h02);
        rdc(6'h14, 8'hAA);
        rdc(6'h1E, 8'h00);
        rdc(6'h1F, 8'h00);
        chk(irq, 1'b1);
        rdc(6'h23, 8'h0D);
        chk(irq, 1'b0);
        rdc(6'h3F, 8'h00);
        wrap_up();
    end
endmodule

bind can_msg_store can_msg_store_sva #(.BIT_DIV(BIT_DIV)) u_can_msg_store_sva (.clock, .arst_n,
    .sofRequest, .txDone, .txFail, .txActive, .txIndex, .txId, .txIde, .txRtr, .txDlc,
    .txByteCount, .txData, .bitTick, .initMode);
